/* include/lcs_defines.svh */
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH

// bubble lengths in core clock cycles
`define LCS_SNOOP_CYC     2'h2
`define LCS_RELOAD_CYC    2'h3
`define LCS_REPLAY_CYC    2'h3
`define LCS_SPECIAL_CYC   2'h2

// trace buffer room needed to let completion proceed
`define LCS_TCB_NEED      2'h2
`define LCS_TAB_NEED      2'h1

// register map, byte addresses
`define LCS_ADDR_W        4
`define LCS_OFF_CTRL      4'h0
`define LCS_OFF_STATUS    4'h4
`define LCS_OFF_RETIRED   4'h8

// field positions and reset value
`define LCS_CTRL_TRACE_EN 0
`define LCS_CTRL_RST      32'h0000_0000

`endif

/* include/lcs_pkg.sv */
package lcs_pkg;

    // class of the instruction waiting in the reservation station
    typedef enum logic [1:0]
    {
        LCS_OP_PLAIN   = 2'b00,
        LCS_OP_SPECIAL = 2'b01,
        LCS_OP_CACHEOP = 2'b10
    } lcs_op_class_e;

    // tracking of a synchronizing instruction in flight
    typedef enum logic [0:0]
    {
        LCS_SP_IDLE = 1'b0,
        LCS_SP_BUSY = 1'b1
    } lcs_sp_state_e;

    typedef struct packed
    {
        logic          valid;
        logic          is_store;
        logic          addr_rdy;
        logic          data_rdy;
        lcs_op_class_e op_class;
    } lcs_rs_s;

    typedef struct packed
    {
        logic valid;
        logic finished;
        logic is_store;
        logic data_from_slot0;
        logic break_before;
        logic break_after;
        logic is_lr_move;
        logic is_mispred_br;
        logic refetch_ser;
        logic is_isync;
    } lcs_cq_s;

    // snapshot of the load/store start blockers, readable by software
    typedef struct packed
    {
        logic special;
        logic cacheop;
        logic misalign;
        logic replay;
        logic reload;
        logic fwd_beat;
        logic snoop;
        logic operand;
    } lcs_blk_s;

endpackage

/* logic/lcs_stall_ctrl.sv */
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "lcs_defines.svh"

module lcs_stall_ctrl
    import lcs_pkg::*;
#(
    parameter int CNT_W = 2,   // width of bubble counters
    parameter int BUF_W = 4    // width of trace buffer free counts
)
(
    input  wire logic                   i_clk_sys,      // core clock
    input  wire logic                   i_rst_n,        // sync reset
    // reservation station and memory subsystem
    input  wire lcs_rs_s                i_rs,           // waiting op
    input  wire logic                   i_snoop,        // snoop active
    input  wire logic                   i_fwd_beat,     // first beat fwd
    input  wire logic                   i_reload_start, // line write pulse
    input  wire logic                   i_replay,       // replay active
    input  wire logic                   i_misal_second, // second half pulse
    input  wire logic                   i_special_done, // sync op retired
    output logic                        o_ldst_start,   // start granted
    // completion queue
    input  wire lcs_cq_s                i_slot0,        // oldest slot
    input  wire lcs_cq_s                i_slot1,        // second slot
    input  wire logic                   i_refetch_pend, // core flush pending
    input  wire logic [BUF_W-1:0]       i_tcb_free,     // control buf room
    input  wire logic [BUF_W-1:0]       i_tab_free,     // address buf room
    output logic                        o_retire0,      // oldest retires
    output logic                        o_retire1,      // second retires
    // register port
    input  wire logic [`LCS_ADDR_W-1:0] i_addr,         // byte address
    input  wire logic [31:0]            i_wr_data,      // write data
    input  wire logic                   i_wr,           // write strobe
    input  wire logic                   i_rd,           // read strobe
    output logic [31:0]                 o_rd_data       // read data
);

    // shared countdown: reload on an event, else step toward zero
    function automatic logic [CNT_W-1:0] cnt_next
    (
        input logic             load,
        input logic [CNT_W-1:0] load_val,
        input logic [CNT_W-1:0] cur
    );
        logic [CNT_W-1:0] res;
        res = cur;
        if (load)
        begin
            res = load_val;
        end
        else if (cur != '0)
        begin
            res = cur - 1'b1;
        end
        return res;
    endfunction

    logic [31:0]      ctrl_q;
    logic             trace_en;
    logic [CNT_W-1:0] snoop_cnt_q;
    logic [CNT_W-1:0] reload_cnt_q;
    logic [CNT_W-1:0] replay_cnt_q;
    logic [CNT_W-1:0] special_cnt_q;
    logic             replay_q;
    logic             misal_q;
    logic             cacheop_q;
    lcs_sp_state_e    sp_state_q;
    lcs_sp_state_e    sp_state_d;
    lcs_blk_s         blk;
    lcs_blk_s         blk_q;
    logic             op_ready;
    logic             replay_resume;
    logic             refetch_wait_q;
    logic             refetch_need;
    logic             comp_hold;
    logic             slot1_live;
    logic             slot1_ok;
    logic [31:0]      retired_q;
    logic [31:0]      rd_data_d;

    assign trace_en = ctrl_q[`LCS_CTRL_TRACE_EN];

    // load/store start

    // store data can arrive after the start
    assign op_ready = i_rs.addr_rdy
                    & (i_rs.is_store | i_rs.data_rdy);

    // the resume cycle itself is the first of the three bubble cycles
    assign replay_resume = replay_q & ~i_replay;

    always_comb
    begin
        blk          = '0;
        blk.operand  = ~op_ready;
        blk.snoop    = i_snoop | (snoop_cnt_q != '0);
        blk.fwd_beat = i_fwd_beat;
        blk.reload   = reload_cnt_q != '0;
        blk.replay   = i_replay | replay_resume
                     | (replay_cnt_q != '0);
        blk.misalign = i_misal_second | misal_q;
        blk.cacheop  = cacheop_q;
        blk.special  = (sp_state_q == LCS_SP_BUSY)
                     | (special_cnt_q != '0);
    end

    assign o_ldst_start = i_rs.valid & (blk == '0);

    // the snoop cycle itself counts as the first of its two
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            snoop_cnt_q <= '0;
        end
        else
        begin
            snoop_cnt_q <= cnt_next(i_snoop,
                CNT_W'(`LCS_SNOOP_CYC - 2'h1), snoop_cnt_q);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            reload_cnt_q <= '0;
        end
        else
        begin
            reload_cnt_q <= cnt_next(i_reload_start,
                CNT_W'(`LCS_RELOAD_CYC), reload_cnt_q);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            replay_q     <= 1'b0;
            replay_cnt_q <= '0;
        end
        else
        begin
            replay_q     <= i_replay;
            replay_cnt_q <= cnt_next(replay_resume,
                CNT_W'(`LCS_REPLAY_CYC - 2'h1), replay_cnt_q);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            misal_q <= 1'b0;
        end
        else
        begin
            misal_q <= i_misal_second;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            cacheop_q <= 1'b0;
        end
        else
        begin
            cacheop_q <= o_ldst_start
                       & (i_rs.op_class == LCS_OP_CACHEOP);
        end
    end

    // synchronizing op: busy until done, never shorter than the minimum
    always_comb
    begin
        sp_state_d = sp_state_q;
        case (sp_state_q)
            LCS_SP_IDLE:
            begin
                if (o_ldst_start && i_rs.op_class == LCS_OP_SPECIAL)
                begin
                    sp_state_d = LCS_SP_BUSY;
                end
            end
            LCS_SP_BUSY:
            begin
                if (i_special_done)
                begin
                    sp_state_d = LCS_SP_IDLE;
                end
            end
            default:
            begin
                sp_state_d = LCS_SP_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            sp_state_q    <= LCS_SP_IDLE;
            special_cnt_q <= '0;
        end
        else
        begin
            sp_state_q    <= sp_state_d;
            special_cnt_q <= cnt_next(
                o_ldst_start && i_rs.op_class == LCS_OP_SPECIAL,
                CNT_W'(`LCS_SPECIAL_CYC), special_cnt_q);
        end
    end

    // completion

    assign comp_hold = i_refetch_pend
                     | (trace_en
                        & (i_tcb_free < BUF_W'(`LCS_TCB_NEED)))
                     | (trace_en
                        & (i_tab_free < BUF_W'(`LCS_TAB_NEED)));

    assign refetch_need = i_slot0.valid & i_slot0.finished
                        & i_slot0.refetch_ser & ~i_slot0.is_isync;

    // extra cycle for refetch-serialized ops, isync excluded
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            refetch_wait_q <= 1'b0;
        end
        else
        begin
            refetch_wait_q <= refetch_need & ~o_retire0;
        end
    end

    always_comb
    begin
        o_retire0 = i_slot0.valid & i_slot0.finished
                  & ~comp_hold
                  & (~refetch_need | refetch_wait_q);
    end

    assign slot1_live = i_slot1.valid
                      & ~i_slot0.refetch_ser
                      & ~i_slot0.is_mispred_br;

    always_comb
    begin
        slot1_ok = slot1_live & i_slot1.finished;
        if (i_slot0.is_store && i_slot1.is_store)
        begin
            slot1_ok = 1'b0;
        end
        if (i_slot1.is_store && i_slot1.data_from_slot0)
        begin
            slot1_ok = 1'b0;
        end
        if (i_slot1.break_before)
        begin
            slot1_ok = 1'b0;
        end
        if (i_slot0.is_lr_move && i_slot1.is_mispred_br)
        begin
            slot1_ok = 1'b0;
        end
        if (i_slot1.refetch_ser && !i_slot1.is_isync)
        begin
            slot1_ok = 1'b0;
        end
        if (i_slot0.break_after)
        begin
            slot1_ok = 1'b0;
        end
    end

    // two slots only, so never more than two retire
    assign o_retire1 = o_retire0 & slot1_ok;

    // registers

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            ctrl_q <= `LCS_CTRL_RST;
        end
        else if (i_wr && i_addr == `LCS_OFF_CTRL)
        begin
            ctrl_q <= {31'h0, i_wr_data[`LCS_CTRL_TRACE_EN]};
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            blk_q <= '0;
        end
        else
        begin
            blk_q <= blk;
        end
    end

    // writing the counter clears it; a retire in that cycle still counts
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            retired_q <= '0;
        end
        else if (i_wr && i_addr == `LCS_OFF_RETIRED)
        begin
            retired_q <= {30'h0, o_retire0 & o_retire1,
                          o_retire0 ^ o_retire1};
        end
        else
        begin
            retired_q <= retired_q + {31'h0, o_retire0}
                                   + {31'h0, o_retire1};
        end
    end

    always_comb
    begin
        rd_data_d = 32'h0;
        case (i_addr)
            `LCS_OFF_CTRL:    rd_data_d = ctrl_q;
            `LCS_OFF_STATUS:  rd_data_d = {24'h0, blk_q};
            `LCS_OFF_RETIRED: rd_data_d = retired_q;
            default:          rd_data_d = 32'h0;
        endcase
    end

    // data valid only in the cycle after the strobe
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_rd_data <= 32'h0;
        end
        else if (i_rd)
        begin
            o_rd_data <= rd_data_d;
        end
        else
        begin
            o_rd_data <= 32'h0;
        end
    end

endmodule

/* tb/lcs_rs_model.sv */
`timescale 1ns/1ps
module lcs_rs_model
    import lcs_pkg::*;
(
    input  wire logic    i_clk_sys, // clock
    input  wire logic    i_rst_n,   // reset
    input  wire logic    i_load,    // load new op
    input  wire lcs_rs_s i_op,      // op to load
    input  wire logic    i_start,   // grant seen
    output lcs_rs_s      o_rs       // waiting op
);
    // the queue behind always holds a ready plain op
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            o_rs <= '0;
        else if (i_load)
            o_rs <= i_op;
        else if (i_start)
            o_rs <= 6'h2C;
    end
endmodule

/* tb/lcs_stall_ctrl_sva.sv */
`timescale 1ns/1ps
module lcs_stall_ctrl_sva
    import lcs_pkg::*;
(
    input wire logic    i_clk_sys,      // clock
    input wire logic    i_rst_n,        // reset
    input wire lcs_rs_s i_rs,           // waiting op
    input wire logic    i_snoop,        // snoop
    input wire logic    i_fwd_beat,     // first beat
    input wire logic    i_reload_start, // reload pulse
    input wire logic    i_replay,       // replay
    input wire logic    i_misal_second, // misaligned pulse
    input wire logic    o_ldst_start,   // start grant
    input wire lcs_cq_s i_slot0,        // oldest slot
    input wire lcs_cq_s i_slot1,        // second slot
    input wire logic    i_refetch_pend, // flush pending
    input wire logic    o_retire0,      // oldest retires
    input wire logic    o_retire1       // second retires
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    a_snoop_block: assert property (
        i_snoop |-> !o_ldst_start ##1 !o_ldst_start)
        else $error("start during snoop");
    a_fwd_block: assert property (
        i_fwd_beat |-> !o_ldst_start)
        else $error("start during forward");
    a_reload_block: assert property (
        i_reload_start |=> !o_ldst_start [*3])
        else $error("start during reload");
    a_replay_block: assert property (
        i_replay |-> !o_ldst_start)
        else $error("start during replay");
    a_replay_tail: assert property (
        $fell(i_replay) |-> !o_ldst_start [*3])
        else $error("start in replay bubble");
    a_misal_block: assert property (
        i_misal_second |-> !o_ldst_start [*2])
        else $error("start in misaligned bubble");
    a_special_gap: assert property (
        o_ldst_start && i_rs.op_class == LCS_OP_SPECIAL
        |=> !o_ldst_start [*2])
        else $error("start after sync op");
    a_cacheop_gap: assert property (
        o_ldst_start && i_rs.op_class == LCS_OP_CACHEOP |=> !o_ldst_start)
        else $error("start after cache op");
    a_break_before: assert property (
        i_slot1.break_before |-> !o_retire1)
        else $error("break-before retired from second slot");
    a_break_after: assert property (
        i_slot0.break_after |-> !o_retire1)
        else $error("second slot retired after break-after");
    a_pend_stall: assert property (
        i_refetch_pend |-> !o_retire0 && !o_retire1)
        else $error("retire with flush pending");
    a_unfinished_hold: assert property (
        !(i_slot0.valid && i_slot0.finished) |-> !o_retire0)
        else $error("unfinished oldest retired");
    a_one_store: assert property (
        o_retire0 && i_slot0.is_store && i_slot1.is_store |-> !o_retire1)
        else $error("two stores retired");
    a_misp_flush: assert property (
        i_slot0.is_mispred_br |-> !o_retire1)
        else $error("second slot after mispredict");
    a_retire_order: assert property (
        o_retire1 |-> o_retire0)
        else $error("second slot retired alone");
endmodule

/* tb/test_lcs_stall_ctrl.sv */
`timescale 1ns/1ps
`include "lcs_defines.svh"
module test_lcs_stall_ctrl
    import lcs_pkg::*;
;
    logic        i_clk_sys = 0, i_rst_n = 0, ld_q = 0;
    logic        i_snoop = 0, i_fwd_beat = 0, i_reload_start = 0;
    logic        i_replay = 0, i_misal_second = 0, i_special_done = 0;
    logic        i_refetch_pend = 0, i_wr = 0, i_rd = 0;
    logic        o_ldst_start, o_retire0, o_retire1;
    lcs_rs_s     rs, op_q = '0;
    lcs_cq_s     i_slot0 = '0, i_slot1 = '0;
    logic [3:0]  i_tcb_free = 4'hF, i_tab_free = 4'hF, i_addr = 4'h0;
    logic [31:0] i_wr_data = 32'h0, o_rd_data;
    int          n_fail = 0, total_checks = 0, cyc_cnt = 0, cnt = 0;
    // {flush pending, oldest, second, retire0, retire1}
    localparam logic [22:0] TB [16] = '{
        {1'h0, 10'h300, 10'h300, 2'h3},
        {1'h0, 10'h000, 10'h300, 2'h0},
        {1'h0, 10'h200, 10'h300, 2'h0},
        {1'h0, 10'h300, 10'h200, 2'h2},
        {1'h0, 10'h380, 10'h380, 2'h2},
        {1'h0, 10'h300, 10'h3C0, 2'h2},
        {1'h0, 10'h300, 10'h320, 2'h2},
        {1'h0, 10'h320, 10'h300, 2'h3},
        {1'h0, 10'h308, 10'h304, 2'h2},
        {1'h0, 10'h304, 10'h300, 2'h2},
        {1'h0, 10'h310, 10'h300, 2'h2},
        {1'h0, 10'h303, 10'h300, 2'h2},
        {1'h0, 10'h300, 10'h380, 2'h3},
        {1'h0, 10'h302, 10'h300, 2'h0},
        {1'h0, 10'h302, 10'h300, 2'h2},
        {1'h1, 10'h300, 10'h300, 2'h0}
    };
    // {control room, address room, both retire}
    localparam logic [8:0] TT [3] = '{
        {4'h1, 4'hF, 1'h0},
        {4'h2, 4'h0, 1'h0},
        {4'h2, 4'h1, 1'h1}
    };

    lcs_stall_ctrl u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_rs(rs), .i_snoop(i_snoop), .i_fwd_beat(i_fwd_beat),
        .i_reload_start(i_reload_start), .i_replay(i_replay),
        .i_misal_second(i_misal_second), .i_special_done(i_special_done),
        .o_ldst_start(o_ldst_start), .i_slot0(i_slot0), .i_slot1(i_slot1),
        .i_refetch_pend(i_refetch_pend), .i_tcb_free(i_tcb_free),
        .i_tab_free(i_tab_free), .o_retire0(o_retire0),
        .o_retire1(o_retire1), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data));
    lcs_rs_model u_rs (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_load(ld_q), .i_op(op_q), .i_start(o_ldst_start), .o_rs(rs));

    always #5 i_clk_sys = ~i_clk_sys;

    task print_verdict;
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge i_clk_sys)
    begin
        cyc_cnt++;
        if (cyc_cnt == 3000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task ck(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 ck("rd_data", o_rd_data, e);
    endtask

    task ld(input lcs_rs_s o);
        @(posedge i_clk_sys);
        ld_q <= 1'b1;
        op_q <= o;
        @(posedge i_clk_sys);
        ld_q <= 1'b0;
    endtask

    // pattern bit k is the grant expected k cycles on; pulses drop after one
    task lsq(input int n, input logic [7:0] p);
        for (int k = 0; k < n; k++)
        begin
            #1 ck("ldst_start", o_ldst_start, p[k]);
            @(posedge i_clk_sys);
            {i_snoop, i_fwd_beat, i_reload_start} <= 3'h0;
            {i_misal_second, i_special_done} <= 2'h0;
        end
    endtask

    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rd(`LCS_OFF_CTRL, 32'h0);
        wr(`LCS_OFF_CTRL, 32'hFFFF_FFFF);
        rd(`LCS_OFF_CTRL, 32'h1);
        rd(4'hC, 32'h0);
        ld(6'h2C);
        lsq(1, 8'h1);
        @(posedge i_clk_sys);
        i_snoop <= 1'b1;
        lsq(3, 8'h4);
        @(posedge i_clk_sys);
        i_fwd_beat <= 1'b1;
        lsq(2, 8'h2);
        @(posedge i_clk_sys);
        i_reload_start <= 1'b1;
        lsq(5, 8'h11);
        @(posedge i_clk_sys);
        i_replay <= 1'b1;
        lsq(2, 8'h0);
        i_replay <= 1'b0;
        lsq(4, 8'h8);
        @(posedge i_clk_sys);
        i_misal_second <= 1'b1;
        lsq(3, 8'h4);
        ld(6'h2E);
        lsq(3, 8'h5);
        ld(6'h2D);
        lsq(4, 8'h1);
        @(posedge i_clk_sys);
        i_special_done <= 1'b1;
        lsq(2, 8'h2);
        ld(6'h38);
        lsq(1, 8'h1);
        ld(6'h28);
        lsq(2, 8'h0);
        rd(`LCS_OFF_STATUS, 32'h1);
        wr(`LCS_OFF_RETIRED, 32'h0);
        foreach (TB[k])
        begin
            @(posedge i_clk_sys);
            {i_refetch_pend, i_slot0, i_slot1} <= TB[k][22:2];
            #1 ck("retire0", o_retire0, TB[k][1]);
            ck("retire1", o_retire1, TB[k][0]);
            cnt += TB[k][1] + TB[k][0];
        end
        foreach (TT[k])
        begin
            @(posedge i_clk_sys);
            {i_tcb_free, i_tab_free} <= TT[k][8:1];
            {i_refetch_pend, i_slot0, i_slot1} <= {1'h0, 10'h300, 10'h300};
            #1 ck("trace_retire0", o_retire0, TT[k][0]);
            ck("trace_retire1", o_retire1, TT[k][0]);
            cnt += 2 * TT[k][0];
        end
        @(posedge i_clk_sys);
        {i_slot0, i_slot1} <= '0;
        rd(`LCS_OFF_RETIRED, cnt);
        // trace off: short trace buffers must not hold completion
        wr(`LCS_OFF_CTRL, 32'h0);
        @(posedge i_clk_sys);
        {i_tcb_free, i_tab_free} <= 8'h10;
        {i_slot0, i_slot1} <= {10'h300, 10'h300};
        #1 ck("untraced_retire0", o_retire0, 1'b1);
        ck("untraced_retire1", o_retire1, 1'b1);
        print_verdict();
    end
endmodule

bind lcs_stall_ctrl lcs_stall_ctrl_sva u_sva (.*);
